// File: rtl/doc_pkg.sv
package doc_pkg;

  // register byte offsets
  localparam logic [7:0]  OFF_MR0     = 8'h00;
  localparam logic [7:0]  OFF_MR1     = 8'h04;
  localparam logic [7:0]  OFF_MR2     = 8'h08;
  localparam logic [7:0]  OFF_CTRL    = 8'h0C;
  localparam logic [7:0]  OFF_STAT    = 8'h10;

  // reset values
  localparam logic [15:0] MR_RST      = 16'h0000;
  localparam logic        LOCK_RST    = 1'b0;

  // field positions
  localparam int          MR0_BL_LSB  = 0;
  localparam int          MR0_CL_LSB  = 4;
  localparam int          MR0_DLL_PD  = 12;
  localparam int          MR1_RN0     = 2;
  localparam int          MR1_AL_LSB  = 3;
  localparam int          MR1_RN1     = 6;
  localparam int          MR1_RN2     = 9;
  localparam int          MR2_CWL_LSB = 3;
  localparam int          MR2_RW0     = 9;
  localparam int          MR2_RW1     = 10;
  localparam int          CTRL_LOCK   = 0;

  // burst-length field encodings
  localparam logic [1:0]  BL_OTF      = 2'h1;
  localparam logic [1:0]  BL_BC4      = 2'h2;

  // latency arithmetic, in CK cycles
  localparam logic [4:0]  CL_BASE     = 5'h04;
  localparam logic [4:0]  CWL_BASE    = 5'h05;
  localparam logic [4:0]  ODT_SUB     = 5'h02;
  localparam logic [4:0]  CWN4_ADD    = 5'h04;
  localparam logic [4:0]  CWN8_ADD    = 5'h06;
  localparam logic [4:0]  CNT_MAX     = 5'h1F;

  // odt history line
  localparam int          HIST_DEPTH  = 32;
  localparam int          HIST_AW     = 5;

  typedef enum logic [1:0] {
    MODE_SYNC  = 2'b00,
    MODE_ASYNC = 2'b01,
    MODE_SREF  = 2'b10
  } doc_mode_e;

  typedef struct packed {
    logic [6:0]  pin1;
    logic [6:0]  pin2;
    logic        ck1;
    logic        ck2;
    logic        ck3;
    logic [15:0] mr0;
    logic [15:0] mr1;
    logic [15:0] mr2;
    logic        dll_lock;
    logic [31:0] rdata;
    doc_mode_e   mode;
    logic        wr_act;
    logic        bc4;
    logic [4:0]  cnt;
    logic        wr_sel;
    logic        term;
    logic        term_o;
  } doc_state_s;

endpackage

// File: rtl/doc_dly_if.sv
`timescale 1ns/1ps
`default_nettype none
interface doc_dly_if;
  logic               shift;
  logic               din;
  logic [4:0]         idx;
  logic               tap;
  modport src (output shift, output din, output idx, input tap);
  modport mem (input shift, input din, input idx, output tap);
endinterface
`default_nettype wire

// File: rtl/doc_hist.sv
`timescale 1ns/1ps
`default_nettype none
module doc_hist
  import doc_pkg::*;
(
  input  wire logic   mclk,
  input  wire logic   rst_q,
  doc_dly_if.mem      dly
);

  typedef struct packed {
    logic [HIST_DEPTH-1:0] hist;
    logic                  tap;
  } doc_hist_s;

  doc_hist_s h_r;
  doc_hist_s h_nxt;

  // one sample per CK rising edge; index 0 is the newest
  always_comb begin
    h_nxt = h_r;
    if (dly.shift) begin
      h_nxt.hist = {h_r.hist[HIST_DEPTH-2:0], dly.din};
    end
    h_nxt.tap = h_r.hist[dly.idx];
  end

  always_ff @(posedge mclk or negedge rst_q) begin
    if (!rst_q) begin
      h_r <= '0;
    end else begin
      h_r <= h_nxt;
    end
  end

  assign dly.tap = h_r.tap;

endmodule
`default_nettype wire

// File: rtl/doc_odt_ctrl.sv
// Chosen here: the plain strobed port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module doc_odt_ctrl
  import doc_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        rst_b,
  input  wire logic [7:0]  addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr_stb,
  input  wire logic        rd_stb,
  output logic      [31:0] rdata,
  input  wire logic        ck,
  input  wire logic        odt,
  input  wire logic        cke,
  input  wire logic        cs_b,
  input  wire logic        ras_b,
  input  wire logic        cas_b,
  input  wire logic        we_b,
  input  wire logic        a12_bc,
  input  wire logic        sref,
  input  wire logic        banks_idle,
  input  wire logic        dq_drive,
  output logic      [1:0]  term_lanes,
  output logic             rtt_wr_sel,
  output logic      [2:0]  rtt_nom_code,
  output logic      [1:0]  rtt_wr_code
);

  function automatic logic [4:0] f_odtl(input logic [15:0] m0,
                                        input logic [15:0] m1,
                                        input logic [15:0] m2);
    logic [4:0] cl;
    logic [4:0] al;
    logic [4:0] cwl;
    cl  = 5'(m0[MR0_CL_LSB +: 3]) + CL_BASE;
    cwl = 5'(m2[MR2_CWL_LSB +: 3]) + CWL_BASE;
    case (m1[MR1_AL_LSB +: 2])
      2'h1:    al = cl - 5'h01;
      2'h2:    al = cl - 5'h02;
      default: al = 5'h00;
    endcase
    return cwl + al - ODT_SUB;
  endfunction

  logic       rs1;
  logic       rst_q;
  doc_state_s s_r;
  doc_state_s s_nxt;
  doc_dly_if  dly();

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rs1   <= 1'b0;
      rst_q <= 1'b0;
    end else begin
      rs1   <= 1'b1;
      rst_q <= rs1;
    end
  end

  doc_hist u_hist (
    .mclk  (mclk),
    .rst_q (rst_q),
    .dly   (dly.mem)
  );

  logic       ck_rise;
  logic       ck_fall;
  logic       odt_s;
  logic       cke_s;
  logic       wr_cmd;
  logic       cfg_on;
  logic       dyn_en;
  logic [4:0] odtl;
  logic [4:0] cwn;
  logic [2:0] nom_bits;
  logic [1:0] wr_bits;

  assign ck_rise  = s_r.ck2 & ~s_r.ck3;
  assign ck_fall  = ~s_r.ck2 & s_r.ck3;
  assign odt_s    = s_r.pin2[6];
  assign cke_s    = s_r.pin2[5];
  // write class: cs low, ras high, cas low, we low, with cke high
  assign wr_cmd   = ck_rise & cke_s & ~s_r.pin2[4] & s_r.pin2[3] & ~s_r.pin2[2] & ~s_r.pin2[1];
  assign nom_bits = {s_r.mr1[MR1_RN2], s_r.mr1[MR1_RN1], s_r.mr1[MR1_RN0]};
  assign wr_bits  = {s_r.mr2[MR2_RW1], s_r.mr2[MR2_RW0]};
  assign cfg_on   = (|nom_bits) | (|wr_bits);
  // dynamic switching is not offered while the dll is off
  assign dyn_en   = (|wr_bits) & s_r.dll_lock;
  assign odtl     = f_odtl(s_r.mr0, s_r.mr1, s_r.mr2);
  assign cwn      = odtl + (s_r.bc4 ? CWN4_ADD : CWN8_ADD);

  // the history tap is the odt sample from odtl CK edges back
  assign dly.shift = ck_rise;
  assign dly.din   = odt_s;
  assign dly.idx   = odtl;

  always_comb begin
    s_nxt      = s_r;
    s_nxt.ck1  = ck;
    s_nxt.ck2  = s_r.ck1;
    s_nxt.ck3  = s_r.ck2;
    s_nxt.pin1 = {odt, cke, cs_b, ras_b, cas_b, we_b, a12_bc};
    s_nxt.pin2 = s_r.pin1;

    s_nxt.rdata = 32'h0000_0000;
    if (wr_stb) begin
      case (addr)
        OFF_MR0:  s_nxt.mr0 = wdata[15:0];
        OFF_MR1:  s_nxt.mr1 = wdata[15:0];
        OFF_MR2:  s_nxt.mr2 = wdata[15:0];
        OFF_CTRL: s_nxt.dll_lock = wdata[CTRL_LOCK];
        default:  s_nxt.dll_lock = s_r.dll_lock;
      endcase
    end
    if (rd_stb) begin
      case (addr)
        OFF_MR0:  s_nxt.rdata = {16'h0000, s_r.mr0};
        OFF_MR1:  s_nxt.rdata = {16'h0000, s_r.mr1};
        OFF_MR2:  s_nxt.rdata = {16'h0000, s_r.mr2};
        OFF_CTRL: s_nxt.rdata = {31'h0000_0000, s_r.dll_lock};
        OFF_STAT: s_nxt.rdata = {19'h0_0000, odtl, 2'h0, s_r.mode, s_r.wr_act,
                                 s_r.wr_sel, s_r.term_o, cfg_on};
        default:  s_nxt.rdata = 32'h0000_0000;
      endcase
    end

    // frozen dll in precharge power-down switches to asynchronous response
    if (sref) begin
      s_nxt.mode = MODE_SREF;
    end else if (!cke_s && banks_idle && !s_r.mr0[MR0_DLL_PD]) begin
      s_nxt.mode = MODE_ASYNC;
    end else begin
      s_nxt.mode = MODE_SYNC;
    end

    if (s_r.wr_act && (s_r.cnt >= cwn)) begin
      s_nxt.wr_act = 1'b0;
    end else if (ck_rise && s_r.wr_act && (s_r.cnt != CNT_MAX)) begin
      s_nxt.cnt = s_r.cnt + 5'h01;
    end
    // a later write simply restarts the window from its own edge
    if (wr_cmd && dyn_en) begin
      s_nxt.wr_act = 1'b1;
      s_nxt.cnt    = 5'h00;
      case (s_r.mr0[MR0_BL_LSB +: 2])
        BL_BC4:  s_nxt.bc4 = 1'b1;
        BL_OTF:  s_nxt.bc4 = ~s_r.pin2[0];
        default: s_nxt.bc4 = 1'b0;
      endcase
    end

    // on/off follows odt, configuration and the power mode (sref, cke, banks_idle), never command decode
    if (s_nxt.mode == MODE_SREF) begin
      s_nxt.term   = 1'b0;
      s_nxt.wr_sel = 1'b0;
      s_nxt.wr_act = 1'b0;
    end else if (!cfg_on) begin
      s_nxt.term   = 1'b0;
    end else if (s_nxt.mode == MODE_ASYNC) begin
      s_nxt.term   = odt_s;
    end else if (ck_fall) begin
      // applied on the CK falling edge after the latency count runs out
      s_nxt.term   = dly.tap;
      s_nxt.wr_sel = s_r.wr_act && (s_r.cnt >= odtl) && (s_r.cnt < cwn);
    end
    if (!dyn_en) begin
      s_nxt.wr_sel = 1'b0;
    end
    // no termination while our own drivers own the data lines
    s_nxt.term_o = s_nxt.term & ~dq_drive;
  end

  always_ff @(posedge mclk or negedge rst_q) begin
    if (!rst_q) begin
      s_r          <= '0;
      s_r.mr0      <= MR_RST;
      s_r.mr1      <= MR_RST;
      s_r.mr2      <= MR_RST;
      s_r.dll_lock <= LOCK_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign rdata        = s_r.rdata;
  assign term_lanes   = {2{s_r.term_o}};
  assign rtt_wr_sel   = s_r.wr_sel;
  assign rtt_nom_code = nom_bits;
  assign rtt_wr_code  = wr_bits;

  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_q);

  sequence s_wr_start;
    wr_cmd && dyn_en && !sref;
  endsequence

  sequence s_cnw_fall;
    ck_fall && s_r.wr_act && (s_r.cnt == odtl) && dyn_en && !sref
      && (s_nxt.mode == MODE_SYNC) && cfg_on && (odtl < cwn);
  endsequence

  property p_sref_off;
    sref |=> (term_lanes == 2'h0) && !rtt_wr_sel;
  endproperty
  a_sref_off: assert property (p_sref_off) else $error("termination on in self-refresh");

  property p_cfg_off;
    !cfg_on ##1 !cfg_on |-> (term_lanes == 2'h0);
  endproperty
  a_cfg_off: assert property (p_cfg_off) else $error("termination on with config off");

  property p_drive_off;
    dq_drive |=> (term_lanes == 2'h0);
  endproperty
  a_drive_off: assert property (p_drive_off) else $error("termination while driving");

  property p_sync_tap;
    ck_fall && cfg_on && !dq_drive && (s_nxt.mode == MODE_SYNC)
      |=> (term_lanes[0] == $past(dly.tap));
  endproperty
  a_sync_tap: assert property (p_sync_tap) else $error("sync termination mismatch");

  property p_async_direct;
    (s_nxt.mode == MODE_ASYNC) && cfg_on && !dq_drive |=> (term_lanes[1] == $past(odt_s));
  endproperty
  a_async_direct: assert property (p_async_direct) else $error("async path delayed");

  property p_wr_start;
    s_wr_start |=> s_r.wr_act && (s_r.cnt == 5'h00);
  endproperty
  a_wr_start: assert property (p_wr_start) else $error("write did not restart count");

  property p_cnw;
    s_cnw_fall |=> rtt_wr_sel;
  endproperty
  a_cnw: assert property (p_cnw) else $error("write strength not selected");

  property p_cwn;
    ck_fall && (s_r.cnt >= cwn) |=> !rtt_wr_sel;
  endproperty
  a_cwn: assert property (p_cwn) else $error("write strength held too long");

  property p_dyn_gate;
    !dyn_en |=> !rtt_wr_sel;
  endproperty
  a_dyn_gate: assert property (p_dyn_gate) else $error("write strength without dynamic mode");

  property p_odtl;
    (s_r.mr1[MR1_AL_LSB +: 2] == 2'h0) |-> (odtl == 5'(s_r.mr2[MR2_CWL_LSB +: 3]) + 5'h03);
  endproperty
  a_odtl: assert property (p_odtl) else $error("odt latency wrong");

  property p_wr_end;
    s_r.wr_act && (s_r.cnt >= cwn) && !(wr_cmd && dyn_en) |=> !s_r.wr_act;
  endproperty
  a_wr_end: assert property (p_wr_end) else $error("write window did not close");

  property p_cnt_step;
    ck_rise && s_r.wr_act && (s_r.cnt < cwn) && !wr_cmd
      |=> (s_r.cnt == $past(s_r.cnt) + 5'h01);
  endproperty
  a_cnt_step: assert property (p_cnt_step) else $error("write count did not step");

  property p_lanes_pair;
    term_lanes[1] == term_lanes[0];
  endproperty
  a_lanes_pair: assert property (p_lanes_pair) else $error("byte lanes disagree");

  property p_sref_mode;
    sref |=> (s_r.mode == MODE_SREF) && !s_r.wr_act;
  endproperty
  a_sref_mode: assert property (p_sref_mode) else $error("self-refresh not entered");

endmodule
`default_nettype wire

// File: testbench/doc_mc_model.sv
`timescale 1ns/1ps
`default_nettype none
module doc_mc_model (
  output logic ck,
  output logic odt,
  output logic cke,
  output logic cs_b,
  output logic ras_b,
  output logic cas_b,
  output logic we_b,
  output logic a12_bc
);
  // the memory clock must keep running, so it is free running here
  initial begin
    ck = 1'b0;
    odt = 1'b0;
    cke = 1'b1;
    cs_b = 1'b1;
    ras_b = 1'b1;
    cas_b = 1'b1;
    we_b = 1'b1;
    a12_bc = 1'b0;
    forever #80 ck = ~ck;
  end
  // pins change on the falling edge, half a cycle ahead of the sampling edge
  task automatic set_odt(input logic v);
    @(negedge ck);
    odt <= v;
  endtask
  task automatic set_cke(input logic v);
    @(negedge ck);
    cke <= v;
  endtask
  task automatic wr_cmd(input logic bl8);
    @(negedge ck);
    cs_b <= 1'b0;
    ras_b <= 1'b1;
    cas_b <= 1'b0;
    we_b <= 1'b0;
    a12_bc <= bl8;
    @(negedge ck);
    cs_b <= 1'b1;
    cas_b <= 1'b1;
    we_b <= 1'b1;
    // a released address line must not keep showing the old value
    a12_bc <= ~bl8;
  endtask
endmodule
`default_nettype wire

// File: testbench/doc_odt_ctrl_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module doc_odt_ctrl_tb_top;
  import doc_pkg::*;
  logic        mclk, rst_b, wr_stb, rd_stb, sref, banks_idle, dq_drive;
  logic [7:0]  addr;
  logic [31:0] wdata, rdata;
  logic        ck, odt, cke, cs_b, ras_b, cas_b, we_b, a12_bc, rtt_wr_sel;
  logic [1:0]  term_lanes, rtt_wr_code;
  logic [2:0]  rtt_nom_code;
  int          n_mismatch, n_compared;

  doc_mc_model u_mc (.ck(ck), .odt(odt), .cke(cke), .cs_b(cs_b), .ras_b(ras_b),
    .cas_b(cas_b), .we_b(we_b), .a12_bc(a12_bc));
  doc_odt_ctrl u_dut (.mclk(mclk), .rst_b(rst_b), .addr(addr), .wdata(wdata),
    .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .ck(ck), .odt(odt), .cke(cke),
    .cs_b(cs_b), .ras_b(ras_b), .cas_b(cas_b), .we_b(we_b), .a12_bc(a12_bc),
    .sref(sref), .banks_idle(banks_idle), .dq_drive(dq_drive),
    .term_lanes(term_lanes), .rtt_wr_sel(rtt_wr_sel), .rtt_nom_code(rtt_nom_code),
    .rtt_wr_code(rtt_wr_code));

  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  task automatic stop_test;
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    @(posedge mclk);
    wr_stb <= 1'b0;
  endtask

  task automatic reg_rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge mclk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge mclk);
    rd_stb <= 1'b0;
    #1 chk(rdata, e);
  endtask

  task automatic ck_falls(input int n);
    repeat (n) @(negedge ck);
  endtask

  task automatic mclks(input int n);
    repeat (n) @(posedge mclk);
  endtask

  // odt sampled at rise k: off at the fall after k+l, on at the fall after k+l+1
  task automatic cfg_lat(input logic [15:0] m0, input logic [15:0] m1,
                         input logic [15:0] m2, input int l, input logic [1:0] on);
    reg_wr(OFF_MR0, {16'h0000, m0});
    reg_wr(OFF_MR1, {16'h0000, m1});
    reg_wr(OFF_MR2, {16'h0000, m2});
    mclks(1);
    chk(rtt_nom_code, {m1[9], m1[6], m1[2]});
    chk(rtt_wr_code, {m2[10], m2[9]});
    u_mc.set_odt(1'b1);
    ck_falls(l + 1);
    chk(term_lanes, 2'h0);
    ck_falls(1);
    chk(term_lanes, on);
    ck_falls(8);
    u_mc.set_odt(1'b0);
    ck_falls(l + 1);
    chk(term_lanes, on);
    ck_falls(1);
    chk(term_lanes, 2'h0);
  endtask

  task automatic dyn(input logic [15:0] m0, input logic bl8, input int n);
    reg_wr(OFF_MR0, {16'h0000, m0});
    reg_wr(OFF_MR1, 32'h0000_0004);
    reg_wr(OFF_MR2, 32'h0000_0200);
    reg_wr(OFF_CTRL, 32'h0000_0001);
    u_mc.set_odt(1'b1);
    ck_falls(2);
    u_mc.wr_cmd(bl8);
    ck_falls(3);
    chk(rtt_wr_sel, 1'b0);
    ck_falls(1);
    chk(rtt_wr_sel, 1'b1);
    chk(term_lanes, 2'h3);
    ck_falls(n - 1);
    chk(rtt_wr_sel, 1'b1);
    ck_falls(1);
    chk(rtt_wr_sel, 1'b0);
    u_mc.set_odt(1'b0);
    ck_falls(8);
  endtask

  task automatic regs_after_reset;
    chk(term_lanes, 2'h0);
    reg_rd(OFF_MR0, 32'h0000_0000);
    reg_rd(OFF_CTRL, 32'h0000_0000);
    reg_rd(OFF_STAT, 32'h0000_0300);
    reg_rd(8'h14, 32'h0000_0000);
    reg_wr(OFF_MR1, 32'hFFFF_1234);
    reg_rd(OFF_MR1, 32'h0000_1234);
    reg_wr(OFF_STAT, 32'hFFFF_FFFF);
    reg_rd(OFF_STAT, 32'h0000_0501);
  endtask

  task automatic gates;
    reg_wr(OFF_MR1, 32'h0000_0004);
    reg_wr(OFF_MR2, 32'h0000_0000);
    u_mc.wr_cmd(1'b1);
    ck_falls(8);
    chk(term_lanes, 2'h0);
    mclks(1);
    sref <= 1'b1;
    u_mc.set_odt(1'b1);
    ck_falls(8);
    chk(term_lanes, 2'h0);
    mclks(1);
    sref <= 1'b0;
    ck_falls(8);
    chk(term_lanes, 2'h3);
    mclks(1);
    dq_drive <= 1'b1;
    mclks(3);
    chk(term_lanes, 2'h0);
    dq_drive <= 1'b0;
    mclks(3);
    chk(term_lanes, 2'h3);
    u_mc.set_odt(1'b0);
    ck_falls(8);
    // frozen dll in precharge power-down skips the posted latency
    reg_wr(OFF_MR1, 32'h0000_000C);
    banks_idle <= 1'b1;
    u_mc.set_cke(1'b0);
    u_mc.set_odt(1'b1);
    ck_falls(1);
    chk(term_lanes, 2'h3);
    ck_falls(3);
    u_mc.set_odt(1'b0);
    ck_falls(1);
    chk(term_lanes, 2'h0);
    // dll kept running in precharge power-down: the posted latency applies again
    reg_wr(OFF_MR0, 32'h0000_1000);
    ck_falls(8);
    u_mc.set_odt(1'b1);
    ck_falls(1);
    chk(term_lanes, 2'h0);
    ck_falls(7);
    chk(term_lanes, 2'h3);
    u_mc.set_odt(1'b0);
    ck_falls(8);
    chk(term_lanes, 2'h0);
    u_mc.set_cke(1'b1);
    mclks(1);
    banks_idle <= 1'b0;
    ck_falls(8);
    // dll off: write strength cleared first, odt held low throughout
    reg_wr(OFF_MR2, 32'h0000_0000);
    reg_wr(OFF_CTRL, 32'h0000_0000);
    u_mc.wr_cmd(1'b1);
    ck_falls(8);
    chk(term_lanes, 2'h0);
    chk(rtt_wr_sel, 1'b0);
  endtask

  initial begin
    #1ms;
    n_mismatch++;
    stop_test();
  end

  initial begin
    n_mismatch = 0;
    n_compared = 0;
    rst_b = 1'b0;
    wr_stb = 1'b0;
    rd_stb = 1'b0;
    sref = 1'b0;
    banks_idle = 1'b0;
    dq_drive = 1'b0;
    addr = 8'h00;
    wdata = 32'h0000_0000;
    mclks(8);
    rst_b <= 1'b1;
    mclks(3);
    regs_after_reset();
    // termination is only exercised with the dll locked
    reg_wr(OFF_CTRL, 32'h0000_0001);
    cfg_lat(16'h0000, 16'h0000, 16'h0000, 3, 2'h0);
    cfg_lat(16'h0000, 16'h0004, 16'h0000, 3, 2'h3);
    cfg_lat(16'h0000, 16'h0040, 16'h0008, 4, 2'h3);
    cfg_lat(16'h0000, 16'h020C, 16'h0000, 6, 2'h3);
    cfg_lat(16'h0010, 16'h0014, 16'h0000, 6, 2'h3);
    cfg_lat(16'h0010, 16'h000C, 16'h0000, 7, 2'h3);
    cfg_lat(16'h0000, 16'h0000, 16'h0200, 3, 2'h3);
    cfg_lat(16'h0000, 16'h0000, 16'h0400, 3, 2'h3);
    dyn(16'h0000, 1'b0, 6);
    dyn(16'h0002, 1'b1, 4);
    dyn(16'h0001, 1'b1, 6);
    dyn(16'h0001, 1'b0, 4);
    gates();
    stop_test();
  end
endmodule
`default_nettype wire
